// File: hw/asc_pkg.sv
// constants shared by the angle sensor spi command interpreter
// assumes a 40 mhz system clock; all times are converted to cycles here
package asc_pkg;

	// clock and timing
	localparam int ASC_CLK_PERIOD_NS = 25;
	localparam int ASC_REFRESH_NS = 1000;
	localparam int ASC_REFRESH_CYC = (ASC_REFRESH_NS + ASC_CLK_PERIOD_NS - 1) / ASC_CLK_PERIOD_NS;
	localparam int ASC_STORE_ONE_US = 23000;
	localparam int ASC_STORE_ALL_US = 704000;
	localparam int ASC_RESTORE_US = 240;
	localparam int ASC_STORE_ONE_CYC = (ASC_STORE_ONE_US * 1000 + ASC_CLK_PERIOD_NS - 1) / ASC_CLK_PERIOD_NS;
	localparam int ASC_STORE_ALL_CYC = (ASC_STORE_ALL_US * 1000 + ASC_CLK_PERIOD_NS - 1) / ASC_CLK_PERIOD_NS;
	localparam int ASC_RESTORE_CYC = (ASC_RESTORE_US * 1000 + ASC_CLK_PERIOD_NS - 1) / ASC_CLK_PERIOD_NS;
	localparam int ASC_NV_CNT_W = 25;
	localparam int ASC_REF_CNT_W = 6;

	// frame layout
	localparam int ASC_FRAME_W = 16;
	localparam int ASC_CMD_MSB = 15;
	localparam int ASC_CMD_LSB = 13;
	localparam int ASC_ADDR_MSB = 12;
	localparam int ASC_ADDR_LSB = 8;
	localparam int ASC_DATA_MSB = 7;
	localparam int ASC_BIT_CNT_W = 4;
	localparam logic [3:0] ASC_LAST_BIT = 4'hf;

	// register file
	localparam int ASC_NUM_REGS = 32;
	localparam logic [4:0] ASC_REG_ROT = 5'h09;
	localparam int ASC_ROT_CCW_BIT = 7;
	localparam logic [4:0] ASC_REG_ERR = 5'h1a;
	localparam int ASC_PARITY_FAULT_FLAG_BIT = 3;
	localparam int ASC_MEM_FAULT_BIT = 2;
	localparam logic [7:0] ASC_ERR_MASK = 8'h0e;

	// factory contents of the configuration registers
	localparam logic [7:0] ASC_FACTORY [ASC_NUM_REGS] = '{
		8'h00, 8'h00, 8'h00, 8'h00, 8'h6e, 8'h00, 8'h00, 8'h87,
		8'h00, 8'h00, 8'h00, 8'he0, 8'h00, 8'h00, 8'h90, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	// command codes in frame bits 15..13
	typedef enum logic [2:0] {
		ASC_CMD_ANGLE = 3'h0,
		ASC_CMD_CLEAR = 3'h1,
		ASC_CMD_READ = 3'h2,
		ASC_CMD_SPARE = 3'h3,
		ASC_CMD_WRITE = 3'h4,
		ASC_CMD_RESTORE = 3'h5,
		ASC_CMD_STORE_ALL = 3'h6,
		ASC_CMD_STORE_ONE = 3'h7
	} asc_cmd_t;

	typedef enum logic [1:0] {
		ASC_NV_BOOT,
		ASC_NV_IDLE,
		ASC_NV_STORE,
		ASC_NV_RESTORE
	} asc_nv_state_t;

endpackage

// File: hw/asc_sync.sv
// two flip-flop synchroniser for a bundle of independent levels
// assumes each bit is a level that stays put for several destination cycles
`timescale 1ns/1ps
`default_nettype none
module asc_sync #(
	parameter int WIDTH = 2
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// levels
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else
		begin
			meta_ff <= async_i;
			sync_ff <= meta_ff;
		end
	end

	assign sync_o = sync_ff;
endmodule
`default_nettype wire

// File: hw/asc_spi_cmd.sv
// spi slave command interpreter of the angle sensor
// assumes angle_i is a fresh result on sys_clk_i, and the master keeps cs low
// at least 120 ns before the first sclk edge so the frozen reply has settled
// How it works
// RULE1 - every 1 us a new angle is loaded into the output buffer when unfrozen
// RULE2 - cs falling freezes the output buffer; cs rising releases it
// RULE3 - code 000 returns the full 16-bit angle, msb first, over 16 clocks
// RULE4 - the master may stop early; leading bits form a truncated angle
// RULE5 - fast reads keep returning the same angle until refreshed
// RULE6 - read request is code 010, 5-bit address, low byte all zero
// RULE7 - second frame of a read returns angle 15..8 and the register byte
// RULE8 - write request is code 100, 5-bit address, then 8-bit value
// RULE9 - second frame of a write returns angle 15..8 and the stored byte
// RULE10 - parity fault flag reads back at register 26 bit 3
// RULE11 - register 9 bit 7 set selects counterclockwise as positive
// RULE12 - at start-up all stored values are copied into working registers; the code copies all but register 26
// RULE13 - store or restore arriving while memory is busy is ignored
// RULE14 - busy output high during a memory operation, low when idle
// RULE15 - code 111 stores one addressed register, angle returned next
// RULE16 - code 110 stores all registers, angle returned next
// RULE17 - code 101 restores all registers, angle returned next; the code restores all but register 26
// RULE18 - code 001 clears error pin and register 26 flags, angle returned
// RULE19 - master writes registers first, then issues a store
// RULE20 - busy lasts at least 23 ms for one store, 704 ms for all
// RULE21 - spi modes 0 and 3 are both accepted without configuration
// RULE22 - code 011 acts as an angle read and changes nothing
`timescale 1ns/1ps
`default_nettype none
module asc_spi_cmd
	import asc_pkg::*;
#(
	parameter int STORE_ONE_CYC = ASC_STORE_ONE_CYC,
	parameter int STORE_ALL_CYC = ASC_STORE_ALL_CYC,
	parameter int RESTORE_CYC = ASC_RESTORE_CYC
) (
	// system clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// spi link
	input wire logic spi_sclk_i,
	input wire logic spi_cs_b_i,
	input wire logic spi_mosi_i,
	output logic spi_miso_o,
	output logic spi_miso_oe_b_o,
	// angle front end
	input wire logic [15:0] angle_i,
	// status and configuration pins
	output logic nonvolatile_busy_output_o,
	output logic error_o,
	output logic rot_ccw_o
);
	////////////////////////////////////////////////////////////////////////////
	// link domain: shift in on rising sclk, present on falling sclk

	logic [ASC_BIT_CNT_W-1:0] bit_cnt_ff, nxt_bit_cnt;
	logic [ASC_FRAME_W-1:0] shift_ff, nxt_shift;
	logic [ASC_FRAME_W-1:0] frame_word_ff, nxt_frame_word;
	logic frame_tgl_ff, nxt_frame_tgl;
	logic [ASC_BIT_CNT_W-1:0] out_idx_ff;
	logic [ASC_FRAME_W-1:0] resp_ff, nxt_resp;

	always_comb
	begin
		nxt_shift = {shift_ff[ASC_FRAME_W-2:0], spi_mosi_i};
		nxt_bit_cnt = bit_cnt_ff + 4'h1;
		nxt_frame_word = frame_word_ff;
		nxt_frame_tgl = frame_tgl_ff;
		// a frame counts only once all 16 bits are in; a short angle read needs nothing here
		if (bit_cnt_ff == ASC_LAST_BIT) // see RULE4
		begin
			nxt_frame_word = nxt_shift;
			nxt_frame_tgl = ~frame_tgl_ff;
		end
	end

	// cs high holds the bit counter at zero between frames
	always_ff @(posedge spi_sclk_i or posedge spi_cs_b_i)
	begin
		if (spi_cs_b_i)
		begin
			bit_cnt_ff <= '0;
			shift_ff <= '0;
		end
		else
		begin
			bit_cnt_ff <= nxt_bit_cnt;
			shift_ff <= nxt_shift;
		end
	end

	// the toggle must survive cs going high, so it only sees the system reset
	always_ff @(posedge spi_sclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			frame_word_ff <= '0;
			frame_tgl_ff <= 1'b0;
		end
		else
		begin
			frame_word_ff <= nxt_frame_word;
			frame_tgl_ff <= nxt_frame_tgl;
		end
	end

	// falling edges copy the rising-edge count; in mode 3 the first falling edge
	// comes before any rising edge and so still shows the msb
	always_ff @(negedge spi_sclk_i or posedge spi_cs_b_i) // see RULE21
	begin
		if (spi_cs_b_i)
			out_idx_ff <= '0;
		else
			out_idx_ff <= bit_cnt_ff;
	end

	// resp_ff is frozen in the system domain while cs is low, so it is quasi-static here
	assign spi_miso_o = resp_ff[ASC_LAST_BIT - out_idx_ff]; // see RULE3
	assign spi_miso_oe_b_o = spi_cs_b_i;

	////////////////////////////////////////////////////////////////////////////
	// crossing into the system domain

	logic [1:0] sync_in;
	logic [1:0] sync_out;
	logic cs_b_sync;
	logic tgl_sync;
	logic cs_prev_ff, nxt_cs_prev;
	logic tgl_prev_ff, nxt_tgl_prev;

	assign sync_in = {~spi_cs_b_i, frame_tgl_ff}; // cs travels inverted so a reset synchroniser reads as deselected

	asc_sync #(
		.WIDTH(2)
	) u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.async_i(sync_in),
		.sync_o(sync_out)
	);

	assign cs_b_sync = ~sync_out[1];
	assign tgl_sync = sync_out[0];

	logic frozen;
	logic cs_fall;
	logic frame_ev;
	asc_cmd_t cmd;
	logic [4:0] addr;
	logic [7:0] wdata;

	assign frozen = ~cs_b_sync;
	assign cs_fall = cs_prev_ff & ~cs_b_sync;
	assign frame_ev = tgl_sync ^ tgl_prev_ff;
	// frame_word_ff stays put for a whole further frame, far longer than the sync delay
	assign cmd = asc_cmd_t'(frame_word_ff[ASC_CMD_MSB:ASC_CMD_LSB]);
	assign addr = frame_word_ff[ASC_ADDR_MSB:ASC_ADDR_LSB];
	assign wdata = frame_word_ff[ASC_DATA_MSB:0];

	////////////////////////////////////////////////////////////////////////////
	// system domain: output buffer, registers, memory sequencing

	logic [ASC_REF_CNT_W-1:0] ref_cnt_ff, nxt_ref_cnt;
	logic [15:0] buf_ff, nxt_buf;
	logic pend_reg_ff, nxt_pend_reg;
	logic [7:0] pend_val_ff, nxt_pend_val;
	logic [7:0] regs_ff [ASC_NUM_REGS];
	logic [7:0] nxt_regs [ASC_NUM_REGS];
	logic [7:0] nvm_ff [ASC_NUM_REGS];
	logic [7:0] nxt_nvm [ASC_NUM_REGS];
	asc_nv_state_t nv_state_ff, nxt_nv_state;
	logic [ASC_NV_CNT_W-1:0] nv_cnt_ff, nxt_nv_cnt;
	logic err_ff, nxt_err;
	logic ref_tick;
	logic nv_idle;

	assign ref_tick = (ref_cnt_ff == ASC_REF_CNT_W'(ASC_REFRESH_CYC - 1));
	assign nv_idle = (nv_state_ff == ASC_NV_IDLE);

	always_comb
	begin
		nxt_cs_prev = cs_b_sync;
		nxt_tgl_prev = tgl_sync;
		nxt_ref_cnt = ref_tick ? '0 : ref_cnt_ff + 6'h01;
		nxt_buf = buf_ff;
		nxt_pend_reg = pend_reg_ff;
		nxt_pend_val = pend_val_ff;
		nxt_regs = regs_ff;
		nxt_nvm = nvm_ff;
		nxt_nv_state = nv_state_ff;
		nxt_nv_cnt = nv_cnt_ff;
		nxt_resp = resp_ff;
		// the buffer only follows the front end while no transfer is running
		if (ref_tick && !frozen) // see RULE1 see RULE5
			nxt_buf = angle_i;
		if (!frozen) // see RULE2
			nxt_resp = pend_reg_ff ? {buf_ff[15:8], pend_val_ff} : buf_ff; // see RULE7 see RULE9
		if (cs_fall)
			nxt_pend_reg = 1'b0;

		// memory sequencing; the copy of a restore happens at the end of its wait
		unique case (nv_state_ff)
			ASC_NV_IDLE:
				nxt_nv_cnt = '0;
			ASC_NV_BOOT, ASC_NV_RESTORE, ASC_NV_STORE:
			begin
				nxt_nv_cnt = nv_cnt_ff - 25'h1;
				if (nv_cnt_ff == '0)
				begin
					nxt_nv_state = ASC_NV_IDLE;
					if (nv_state_ff != ASC_NV_STORE)
						for (int i = 0; i < ASC_NUM_REGS; i++) // see RULE12 see RULE17
							if (5'(i) != ASC_REG_ERR)
								nxt_regs[i] = nvm_ff[i];
				end
			end
		endcase

		// command decode, once per complete frame
		if (frame_ev)
		begin
			unique case (cmd)
				ASC_CMD_ANGLE, ASC_CMD_SPARE: // see RULE3 see RULE22
					nxt_pend_reg = 1'b0;
				ASC_CMD_CLEAR:
				begin
					nxt_pend_reg = 1'b0;
					nxt_regs[ASC_REG_ERR] = regs_ff[ASC_REG_ERR] & ~ASC_ERR_MASK; // see RULE18
				end
				ASC_CMD_READ:
				begin
					nxt_pend_reg = 1'b1;
					nxt_pend_val = regs_ff[addr]; // see RULE7 see RULE10
					// a request with a non-zero low byte is malformed
					if (wdata != 8'h00) // see RULE6
						nxt_regs[ASC_REG_ERR][ASC_PARITY_FAULT_FLAG_BIT] = 1'b1;
				end
				ASC_CMD_WRITE:
				begin
					nxt_pend_reg = 1'b1;
					// the error register is read-only; its ack shows the unchanged byte
					if (addr != ASC_REG_ERR) // see RULE8
					begin
						nxt_regs[addr] = wdata;
						nxt_pend_val = wdata; // see RULE9
					end
					else
						nxt_pend_val = regs_ff[ASC_REG_ERR];
				end
				ASC_CMD_RESTORE, ASC_CMD_STORE_ALL, ASC_CMD_STORE_ONE:
				begin
					nxt_pend_reg = 1'b0;
					if (!nv_idle) // see RULE13
						nxt_regs[ASC_REG_ERR][ASC_MEM_FAULT_BIT] = 1'b1;
					else if (cmd == ASC_CMD_RESTORE)
					begin
						nxt_nv_state = ASC_NV_RESTORE;
						nxt_nv_cnt = ASC_NV_CNT_W'(RESTORE_CYC - 1);
					end
					else if (cmd == ASC_CMD_STORE_ONE)
					begin
						nxt_nv_state = ASC_NV_STORE;
						nxt_nv_cnt = ASC_NV_CNT_W'(STORE_ONE_CYC - 1); // see RULE20
						nxt_nvm[addr] = regs_ff[addr]; // see RULE15 see RULE19
					end
					else
					begin
						nxt_nv_state = ASC_NV_STORE;
						nxt_nv_cnt = ASC_NV_CNT_W'(STORE_ALL_CYC - 1); // see RULE20
						nxt_nvm = regs_ff; // see RULE16
					end
				end
			endcase
		end
		nxt_err = |(nxt_regs[ASC_REG_ERR] & ASC_ERR_MASK); // see RULE18
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			cs_prev_ff <= 1'b1;
			tgl_prev_ff <= 1'b0;
			ref_cnt_ff <= '0;
			buf_ff <= '0;
			resp_ff <= '0;
			pend_reg_ff <= 1'b0;
			pend_val_ff <= '0;
			regs_ff <= ASC_FACTORY;
			nvm_ff <= ASC_FACTORY;
			nv_state_ff <= ASC_NV_BOOT;
			nv_cnt_ff <= ASC_NV_CNT_W'(RESTORE_CYC - 1);
			err_ff <= 1'b0;
		end
		else
		begin
			cs_prev_ff <= nxt_cs_prev;
			tgl_prev_ff <= nxt_tgl_prev;
			ref_cnt_ff <= nxt_ref_cnt;
			buf_ff <= nxt_buf;
			resp_ff <= nxt_resp;
			pend_reg_ff <= nxt_pend_reg;
			pend_val_ff <= nxt_pend_val;
			regs_ff <= nxt_regs;
			nvm_ff <= nxt_nvm;
			nv_state_ff <= nxt_nv_state;
			nv_cnt_ff <= nxt_nv_cnt;
			err_ff <= nxt_err;
		end
	end

	assign nonvolatile_busy_output_o = ~nv_idle; // see RULE14
	assign error_o = err_ff;
	assign rot_ccw_o = regs_ff[ASC_REG_ROT][ASC_ROT_CCW_BIT]; // see RULE11

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	a_buf_frozen_hold: assert property (frozen && $past(frozen) |-> $stable(buf_ff)) // see RULE2
		else $error("output buffer changed during a transfer");
	a_buf_refresh_load: assert property (ref_tick && !frozen |=> buf_ff == $past(angle_i)) // see RULE1
		else $error("angle not loaded on refresh");
	a_buf_refresh_gap: assert property (ref_tick |=> (!ref_tick)[*8]) // see RULE5
		else $error("refresh ticks too close");
	a_read_reply_byte: assert property (frame_ev && cmd == ASC_CMD_READ
		|=> pend_reg_ff && pend_val_ff == $past(regs_ff[addr])) // see RULE7
		else $error("read reply byte wrong");
	a_write_ack_byte: assert property (frame_ev && cmd == ASC_CMD_WRITE && addr != ASC_REG_ERR
		|=> pend_val_ff == $past(wdata) && regs_ff[$past(addr)] == $past(wdata)) // see RULE9
		else $error("write ack byte wrong");
	a_rot_sense_bit: assert property (frame_ev && cmd == ASC_CMD_WRITE && addr == ASC_REG_ROT
		|=> ##1 rot_ccw_o == $past(wdata[ASC_ROT_CCW_BIT], 2)) // see RULE11
		else $error("rotation sense not taken from register 9");
	a_busy_ignore_cmd: assert property (frame_ev && !nv_idle && (cmd == ASC_CMD_STORE_ALL
		|| cmd == ASC_CMD_STORE_ONE || cmd == ASC_CMD_RESTORE)
		|=> $stable(nv_state_ff) && error_o) // see RULE13
		else $error("store while busy was not ignored");
	a_store_busy_hold: assert property (frame_ev && nv_idle && cmd == ASC_CMD_STORE_ONE
		|=> nonvolatile_busy_output_o[*8]) // see RULE14 see RULE20
		else $error("busy not held after a store");
	a_clear_error_pin: assert property (frame_ev && cmd == ASC_CMD_CLEAR ##1 !frame_ev
		|=> !error_o) // see RULE18
		else $error("error pin not cleared");
	a_spare_no_change: assert property (frame_ev && cmd == ASC_CMD_SPARE
		|=> !pend_reg_ff && $stable(regs_ff[ASC_REG_ROT])) // see RULE22
		else $error("spare code changed state");
	a_boot_restore_copy: assert property (nv_state_ff == ASC_NV_BOOT && nv_cnt_ff == '0
		|=> nv_idle && regs_ff[ASC_REG_ROT] == nvm_ff[ASC_REG_ROT]) // see RULE12
		else $error("start-up restore missing");
endmodule
`default_nettype wire

// File: verification/asc_spi_master.sv
// spi master model for the angle sensor link, mode 0 or mode 3
// assumes the bench holds req_i and its qualifiers steady until done_o rises
`timescale 1ns/1ps
`default_nettype none
module asc_spi_master (
	// link clock and request
	input wire logic lclk_i,
	input wire logic req_i,
	input wire logic [15:0] tx_i,
	input wire logic [4:0] nbits_i,
	input wire logic mode3_i,
	input wire logic [2:0] slow_i,
	output logic done_o,
	output logic [15:0] rx_o,
	// spi pins
	output logic sclk_o,
	output logic cs_b_o,
	output logic mosi_o,
	input wire logic miso_i
);
	initial
	begin
		done_o = 1'b0;
		rx_o = 16'h0000;
		sclk_o = 1'b0;
		cs_b_o = 1'b1;
		mosi_o = 1'b0;
		forever
		begin
			wait (req_i === 1'b1);
			@(posedge lclk_i);
			// idle level picks the mode; sclk stands still outside frames
			sclk_o = mode3_i;
			@(posedge lclk_i);
			cs_b_o = 1'b0;
			rx_o = 16'h0000;
			repeat (5) @(posedge lclk_i);
			// fewer than 16 bits ends the read early
			for (int i = 0; i < nbits_i; i++)
			begin
				sclk_o = 1'b0;
				mosi_o = tx_i[15 - i];
				repeat (slow_i) @(posedge lclk_i);
				@(negedge lclk_i);
				sclk_o = 1'b1;
				rx_o = {rx_o[14:0], miso_i};
				repeat (slow_i) @(negedge lclk_i);
				@(posedge lclk_i);
			end
			sclk_o = mode3_i;
			@(posedge lclk_i);
			cs_b_o = 1'b1;
			// released line must not look like the last bit
			mosi_o = ~mosi_o;
			repeat (5) @(posedge lclk_i);
			done_o = 1'b1;
			wait (req_i === 1'b0);
			done_o = 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: verification/asc_spi_cmd_tb.sv
// self-checking bench for the spi command interpreter
// assumes the master model of asc_spi_master.sv drives the link
`timescale 1ns/1ps
`default_nettype none
module asc_spi_cmd_tb
	import asc_pkg::*;
;
	localparam int ST1 = 200;
	localparam int STA = 400;
	logic sys_clk_i, rst_b_i, lclk, req, mode3, done, sclk, cs_b, mosi, miso, oe_b, busy, err, ccw;
	logic [15:0] tx, rx, angle, r;
	logic [4:0] nbits;
	logic [2:0] slow;
	int fails, total_checks, bcnt, blen, c;

	always #12.5 sys_clk_i = ~sys_clk_i;
	initial
	begin
		lclk = 1'b0;
		#7;
		forever #16 lclk = ~lclk;
	end

	// length of the last busy period, in system cycles
	always @(posedge sys_clk_i)
	begin
		bcnt <= busy ? bcnt + 1 : 0;
		if (!busy && bcnt != 0)
			blen <= bcnt;
	end

	asc_spi_cmd #(.STORE_ONE_CYC(ST1), .STORE_ALL_CYC(STA), .RESTORE_CYC(20)) dut (
		.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .spi_sclk_i(sclk), .spi_cs_b_i(cs_b),
		.spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_b_o(oe_b), .angle_i(angle),
		.nonvolatile_busy_output_o(busy), .error_o(err), .rot_ccw_o(ccw));

	asc_spi_master master (.lclk_i(lclk), .req_i(req), .tx_i(tx), .nbits_i(nbits), .mode3_i(mode3),
		.slow_i(slow), .done_o(done), .rx_o(rx), .sclk_o(sclk), .cs_b_o(cs_b), .mosi_o(mosi),
		.miso_i(miso));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic wait_lvl(input bit on_busy, input logic v, output int n);
		n = 0;
		while ((on_busy ? busy : done) !== v)
		begin
			@(posedge sys_clk_i);
			n++;
			if (n > 30000)
			begin
				fails++;
				$display("wrong value wait expected %b seen timeout", v);
				finish_test();
			end
		end
	endtask

	task automatic frame(input logic [15:0] w, input logic [4:0] n, output logic [15:0] q);
		int k;
		tx <= w;
		nbits <= n;
		req <= 1'b1;
		@(posedge sys_clk_i);
		wait_lvl(1'b0, 1'b1, k);
		q = rx;
		req <= 1'b0;
		check("miso enable idle", {15'h0000, oe_b}, 16'h0001);
		@(posedge sys_clk_i);
		wait_lvl(1'b0, 1'b0, k);
	endtask

	// request frame, then a filler frame that carries the reply
	task automatic xfer2(input logic [15:0] w, output logic [15:0] q);
		logic [15:0] d;
		frame(w, 5'h10, d);
		frame(16'h0000, 5'h10, q);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		sys_clk_i = 1'b0;
		rst_b_i = 1'b0;
		req = 1'b0;
		tx = 16'h0000;
		nbits = 5'h10;
		mode3 = 1'b0;
		slow = 3'h0;
		angle = 16'ha5c3;
		repeat (2) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		@(posedge sys_clk_i);
		check("busy at boot", {15'h0000, busy}, 16'h0001);
		wait_lvl(1'b1, 1'b0, c);
		// the buffer starts empty; let one refresh land before frames freeze it
		repeat (45) @(posedge sys_clk_i);
		xfer2({3'h2, 5'h04, 8'h00}, r);
		check("boot reg 4", r, {8'ha5, ASC_FACTORY[4]});
		check("rot at boot", {15'h0000, ccw}, 16'h0000);
		$display("test boot done");

		for (int m = 0; m < 2; m++)
		begin
			mode3 <= m[0];
			frame(16'h0000, 5'h10, r);
			check("angle", r, 16'ha5c3);
			frame(16'h0000, 5'h08, r);
			check("short angle", r, 16'h00a5);
		end
		$display("test angle done");

		// slow frame spans several refresh ticks while the angle moves
		slow <= 3'h4;
		fork
			frame(16'h0000, 5'h10, r);
			begin
				repeat (20) @(posedge sys_clk_i);
				angle <= 16'h3c5a;
			end
		join
		check("frozen angle", r, 16'ha5c3);
		slow <= 3'h0;
		repeat (45) @(posedge sys_clk_i);
		frame(16'h0000, 5'h10, r);
		check("refreshed angle", r, 16'h3c5a);
		$display("test freeze done");

		xfer2({3'h4, ASC_REG_ROT, 8'h80}, r);
		check("write ack", r, 16'h3c80);
		check("rot ccw", {15'h0000, ccw}, 16'h0001);
		xfer2({3'h2, ASC_REG_ROT, 8'h00}, r);
		check("read reg 9", r, 16'h3c80);
		frame({3'h2, 5'h05, 8'h01}, 5'h10, r);
		xfer2({3'h2, ASC_REG_ERR, 8'h00}, r);
		check("parity flag", r, 16'h3c08);
		check("error pin", {15'h0000, err}, 16'h0001);
		$display("test registers done");

		// registers written first, then stored
		frame({3'h7, ASC_REG_ROT, 8'h00}, 5'h10, r);
		check("busy on store", {15'h0000, busy}, 16'h0001);
		frame(16'h0000, 5'h10, r);
		check("store one reply", r, 16'h3c5a);
		wait_lvl(1'b1, 1'b0, c);
		// blen is updated on the edge that first sees busy low
		@(posedge sys_clk_i);
		check("store one time", {15'h0000, blen >= ST1}, 16'h0001);
		frame({3'h6, 13'h0000}, 5'h10, r);
		frame(16'h0000, 5'h10, r);
		check("store all reply", r, 16'h3c5a);
		xfer2({3'h4, ASC_REG_ROT, 8'h00}, r);
		frame({3'h5, 13'h0000}, 5'h10, r);
		wait_lvl(1'b1, 1'b0, c);
		@(posedge sys_clk_i);
		check("store all time", {15'h0000, blen >= STA}, 16'h0001);
		check("restore ignored", {15'h0000, ccw}, 16'h0000);
		xfer2({3'h2, ASC_REG_ERR, 8'h00}, r);
		check("memory flag", r, 16'h3c0c);
		frame({3'h5, 13'h0000}, 5'h10, r);
		frame(16'h0000, 5'h10, r);
		check("restore reply", r, 16'h3c5a);
		wait_lvl(1'b1, 1'b0, c);
		check("restored rot", {15'h0000, ccw}, 16'h0001);
		$display("test memory done");

		frame({3'h1, 13'h0000}, 5'h10, r);
		frame(16'h0000, 5'h10, r);
		check("clear reply", r, 16'h3c5a);
		check("error cleared", {15'h0000, err}, 16'h0000);
		xfer2({3'h2, ASC_REG_ERR, 8'h00}, r);
		check("flags cleared", r, 16'h3c00);
		xfer2({3'h3, ASC_REG_ROT, 8'h00}, r);
		check("spare reply", r, 16'h3c5a);
		check("spare keeps rot", {15'h0000, ccw}, 16'h0001);
		$display("test clear done");
		finish_test();
	end
endmodule
`default_nettype wire
